// ===== sac_cfg.svh
// Purpose: Constants for the converter control block
// Assumes: 50 MHz core clock
// Notes:   Offsets are byte addresses on the register port
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

`define SAC_ADDR_W        4
`define SAC_OFF_CTRL      4'h0
`define SAC_OFF_RESULT    4'h4
`define SAC_OFF_DMA       4'h8

`define SAC_CTRL_W        15
`define SAC_CTRL_RESET    15'h6000
`define SAC_START_BIT     0
`define SAC_DMA_EN_BIT    0

`define SAC_RES_W         10
`define SAC_HALF_SCALE    10'h200
`define SAC_LSB_MASK      10'h001
`define SAC_RES_ZERO      10'h000

`define SAC_DIV_W         5
`define SAC_DIV_ZERO      5'h00
`define SAC_DIV_ONE       5'h01

`define SAC_CLK_PERIOD_NS 20
`define SAC_MIN_CONV_NS   20000
`define SAC_MIN_CONV_CYC  ((`SAC_MIN_CONV_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_CNT_W         11
`define SAC_CNT_ZERO      11'h000
`define SAC_CNT_ONE       11'h001

`endif

// ===== sac_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: sac_cfg.svh gives the widths
// Notes:   Control struct matches the control register bit layout
`include "sac_cfg.svh"

package sac_pkg;

  typedef struct packed {
    logic                    bandgap_power_down;
    logic                    standby;
    logic                    mux_en;
    logic                    int_en;
    logic                    clk_gate;
    logic [2:0]              chan;
    logic                    rsvd;
    logic [`SAC_DIV_W-1:0]   div;
    logic                    start;
  } sac_ctrl_type;

  typedef struct packed {
    logic       mux_en;
    logic       ref_en;
    logic       standby;
    logic [2:0] chan;
    logic       sample;
  } sac_analog_type;

  typedef enum logic [3:0] {
    SAC_IDLE   = 4'b0001,
    SAC_SAMPLE = 4'b0010,
    SAC_CONV   = 4'b0100,
    SAC_WAIT   = 4'b1000
  } sac_state_type;

endpackage

// ===== sac_clk_div.sv
// Purpose: Converter clock divider with gate
// Assumes: Divider value may change at any time
// Notes:   A divider of zero gives a tick every cycle
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_clk_div
  import sac_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [`SAC_DIV_W-1:0] div_i,
  input  wire logic                  run_i,
  output logic                       tick_o,
  output logic                       conv_clk_o
);

  logic [`SAC_DIV_W-1:0] cnt_reg;
  logic [`SAC_DIV_W-1:0] cnt_next;
  logic                  tick_reg;
  logic                  tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      cnt_next = `SAC_DIV_ZERO;
    end else if (cnt_reg >= div_i) begin
      cnt_next  = `SAC_DIV_ZERO;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + `SAC_DIV_ONE;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg  <= `SAC_DIV_ZERO;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Converter clock is one system cycle high per divided period
  assign tick_o     = tick_reg;
  assign conv_clk_o = tick_reg;

  tick_spacing_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (tick_o && div_i != `SAC_DIV_ZERO && $stable(div_i)) |=> !tick_o)
    else $error("converter tick came too soon");

  gate_stops_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !run_i |=> !tick_o)
    else $error("converter clock ran while gated");

endmodule

// ===== sac_sar.sv
// Purpose: Successive approximation register
// Assumes: Comparator level is already synchronised
// Notes:   Trial bit walks from MSB to LSB, one per step
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_sar
  import sac_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  preset_i,
  input  wire logic                  step_i,
  input  wire logic                  keep_i,
  output logic [`SAC_RES_W-1:0]      code_o,
  output logic                       last_o
);

  logic [`SAC_RES_W-1:0] code_reg;
  logic [`SAC_RES_W-1:0] code_next;
  logic [`SAC_RES_W-1:0] mask_reg;
  logic [`SAC_RES_W-1:0] mask_next;

  function automatic logic [`SAC_RES_W-1:0] trial(input logic [`SAC_RES_W-1:0] code,
                                                  input logic [`SAC_RES_W-1:0] mask,
                                                  input logic                  keep);
    logic [`SAC_RES_W-1:0] kept;
    kept  = keep ? code : (code & ~mask);
    trial = kept | (mask >> 1);
  endfunction

  always_comb begin
    code_next = code_reg;
    mask_next = mask_reg;
    if (preset_i) begin
      code_next = `SAC_HALF_SCALE;
      mask_next = `SAC_HALF_SCALE;
    end else if (step_i) begin
      code_next = trial(code_reg, mask_reg, keep_i);
      mask_next = mask_reg >> 1;
    end
  end

  // Code is held between conversions so the core sees a steady value
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_reg <= `SAC_RES_ZERO;
      mask_reg <= `SAC_RES_ZERO;
    end else begin
      code_reg <= code_next;
      mask_reg <= mask_next;
    end
  end

  assign code_o = code_reg;
  assign last_o = (mask_reg == `SAC_LSB_MASK);

  preset_half_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    preset_i |=> (code_o == `SAC_HALF_SCALE))
    else $error("approximation not preset to half scale");

  step_shift_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (step_i && !preset_i) |=> (mask_reg == ($past(mask_reg) >> 1)))
    else $error("trial bit did not advance");

endmodule

// ===== sac_top.sv
// Purpose: Control logic of a ten bit successive approximation converter
// Assumes: Single 50 MHz clock, register port with read data one cycle later
// Notes:   Comparator input is asynchronous and passes two flip-flops
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "sac_cfg.svh"

// Functional notes
// - Channel field value n routes analog input n to the converter.
// - Writing start begins a conversion; hardware clears start when it ends.
// - Finished result loads the data register, then converter returns idle unless start is written in that cycle.
// - Approximation register presets to half scale, updates every step.
// - One channel per conversion; new selection applies to next conversion.
// - New result overwrites old data register contents unconditionally.
// - Converter clock equals system clock divided by divider field plus one.
// - Each conversion lasts at least the minimum conversion time.
// - Interrupt at end of conversion only when interrupt enable is one.
// - End of conversion can issue a DMA request.
// - Bandgap bit one powers reference down; resets to one.
// - Standby bit one holds core in power down; resets to one.
// - Mux enable bit zero powers multiplexer down; resets to zero.
// - Results are offset binary and hold their value during power down; a start written in standby still converts and loads a new result.
// - Start bit reads zero after reset; nothing converts until started.
// - DMA control enable bit gates end-of-conversion requests; resets zero.
// - Data register is read-only, ten bits low, upper bits zero.
module sac_top
  import sac_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [`SAC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  input  wire logic                  comp_above_i,
  output sac_analog_type             analog_o,
  output logic [`SAC_RES_W-1:0]      dac_code_o,
  output logic                       conv_clk_o,
  output logic                       eoc_o,
  output logic                       irq_o,
  output logic                       dma_req_o
);

  localparam logic [`SAC_CNT_W-1:0] MinCycLast = `SAC_CNT_W'(`SAC_MIN_CONV_CYC - 1);
  localparam sac_ctrl_type          CtrlReset  = sac_ctrl_type'(`SAC_CTRL_RESET);

  sac_ctrl_type            ctrl_reg;
  sac_ctrl_type            ctrl_next;
  logic                    dma_en_reg;
  logic                    dma_en_next;
  sac_state_type           state_reg;
  sac_state_type           state_next;
  logic [`SAC_CNT_W-1:0]   cnt_reg;
  logic [`SAC_CNT_W-1:0]   cnt_next;
  logic [`SAC_RES_W-1:0]   result_reg;
  logic [`SAC_RES_W-1:0]   result_next;
  logic                    eoc_reg;
  logic                    eoc_next;
  logic                    irq_reg;
  logic                    irq_next;
  logic                    dma_req_reg;
  logic                    dma_req_next;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  sac_analog_type          analog_reg;
  sac_analog_type          analog_next;
  logic                    comp_meta_reg;
  logic                    comp_sync_reg;
  logic                    wr_ctrl;
  logic                    wr_dma;
  logic                    start_req;
  logic                    finish;
  logic                    sar_preset;
  logic                    sar_step;
  logic                    sar_last;
  logic [`SAC_RES_W-1:0]   sar_code;
  logic                    conv_tick;

  function automatic logic [31:0] read_word(input logic [`SAC_ADDR_W-1:0] addr,
                                            input sac_ctrl_type           ctrl,
                                            input logic [`SAC_RES_W-1:0]  result,
                                            input logic                   dma_en);
    logic [31:0] word;
    word = 32'h0000_0000;
    unique case (addr)
      `SAC_OFF_CTRL:   word[`SAC_CTRL_W-1:0] = ctrl;
      `SAC_OFF_RESULT: word[`SAC_RES_W-1:0] = result;
      `SAC_OFF_DMA:    word[`SAC_DMA_EN_BIT] = dma_en;
      default:         word = 32'h0000_0000;
    endcase
    read_word = word;
  endfunction

  sac_clk_div u_clk_div (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .div_i      (ctrl_reg.div),
    .run_i      (ctrl_reg.clk_gate),
    .tick_o     (conv_tick),
    .conv_clk_o (conv_clk_o)
  );

  sac_sar u_sar (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .preset_i   (sar_preset),
    .step_i     (sar_step),
    .keep_i     (comp_sync_reg),
    .code_o     (sar_code),
    .last_o     (sar_last)
  );

  // Comparator level from the analog core is asynchronous
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_above_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  assign wr_ctrl   = reg_wr_i && (reg_addr_i == `SAC_OFF_CTRL);
  assign wr_dma    = reg_wr_i && (reg_addr_i == `SAC_OFF_DMA);
  assign start_req = wr_ctrl && reg_wdata_i[`SAC_START_BIT];
  assign finish    = (state_reg == SAC_WAIT) && (cnt_reg >= MinCycLast);

  always_comb begin
    ctrl_next    = ctrl_reg;
    dma_en_next  = dma_en_reg;
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    result_next  = result_reg;
    eoc_next     = 1'b0;
    irq_next     = 1'b0;
    dma_req_next = 1'b0;
    sar_preset   = 1'b0;
    sar_step     = 1'b0;
    analog_next  = analog_reg;

    if (wr_ctrl) begin
      ctrl_next      = sac_ctrl_type'(reg_wdata_i[`SAC_CTRL_W-1:0]);
      ctrl_next.rsvd = 1'b0;
      // Start reads as busy; a zero written mid-conversion does not abort
      ctrl_next.start = ctrl_reg.start | reg_wdata_i[`SAC_START_BIT];
    end
    if (wr_dma) begin
      dma_en_next = reg_wdata_i[`SAC_DMA_EN_BIT];
    end

    if (cnt_reg < MinCycLast) begin
      cnt_next = cnt_reg + `SAC_CNT_ONE;
    end

    unique case (state_reg)
      SAC_IDLE: begin
        cnt_next = `SAC_CNT_ZERO;
        if (start_req) begin
          state_next        = SAC_SAMPLE;
          sar_preset        = 1'b1;
          analog_next.chan  = ctrl_next.chan;
        end
      end
      SAC_SAMPLE: begin
        if (conv_tick) begin
          state_next = SAC_CONV;
        end
      end
      SAC_CONV: begin
        if (conv_tick) begin
          sar_step = 1'b1;
          if (sar_last) begin
            state_next = SAC_WAIT;
          end
        end
      end
      SAC_WAIT: begin
        if (finish) begin
          // Overwrites any unread result by design
          result_next  = sar_code;
          eoc_next     = 1'b1;
          irq_next     = ctrl_reg.int_en;
          dma_req_next = dma_en_reg;
          if (start_req) begin
            // A start written in the finishing cycle is kept, not lost
            state_next       = SAC_SAMPLE;
            sar_preset       = 1'b1;
            cnt_next         = `SAC_CNT_ZERO;
            analog_next.chan = ctrl_next.chan;
          end else begin
            state_next      = SAC_IDLE;
            ctrl_next.start = 1'b0;
          end
        end
      end
      default: begin
        state_next      = SAC_IDLE;
        ctrl_next.start = 1'b0;
      end
    endcase

    analog_next.mux_en  = ctrl_next.mux_en;
    analog_next.ref_en  = !ctrl_next.bandgap_power_down;
    analog_next.standby = ctrl_next.standby;
    analog_next.sample  = (state_next == SAC_SAMPLE);

    rdata_next = 32'h0000_0000;
    if (reg_rd_i) begin
      rdata_next = read_word(reg_addr_i, ctrl_reg, result_reg, dma_en_reg);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg    <= CtrlReset;
      dma_en_reg  <= 1'b0;
      state_reg   <= SAC_IDLE;
      cnt_reg     <= `SAC_CNT_ZERO;
      result_reg  <= `SAC_RES_ZERO;
      eoc_reg     <= 1'b0;
      irq_reg     <= 1'b0;
      dma_req_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      analog_reg  <= '{mux_en: 1'b0, ref_en: 1'b0, standby: 1'b1, chan: 3'h0, sample: 1'b0};
    end else begin
      ctrl_reg    <= ctrl_next;
      dma_en_reg  <= dma_en_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      result_reg  <= result_next;
      eoc_reg     <= eoc_next;
      irq_reg     <= irq_next;
      dma_req_reg <= dma_req_next;
      rdata_reg   <= rdata_next;
      analog_reg  <= analog_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign analog_o    = analog_reg;
  assign dac_code_o  = sar_code;
  assign eoc_o       = eoc_reg;
  assign irq_o       = irq_reg;
  assign dma_req_o   = dma_req_reg;

  eoc_single_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    eoc_o |=> !eoc_o)
    else $error("end of conversion wider than one cycle");

  result_load_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    eoc_o |-> (result_reg == $past(sar_code)))
    else $error("result not loaded at end of conversion");

  start_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (eoc_o && !$past(start_req)) |-> (!ctrl_reg.start && state_reg == SAC_IDLE))
    else $error("start bit not cleared at end of conversion");

  min_time_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    eoc_o |-> ($past(cnt_reg) >= MinCycLast))
    else $error("conversion shorter than minimum time");

  irq_enable_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (eoc_o || irq_o) |-> (irq_o == (eoc_o && $past(ctrl_reg.int_en))))
    else $error("interrupt does not follow its enable");

  dma_enable_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (eoc_o || dma_req_o) |-> (dma_req_o == (eoc_o && $past(dma_en_reg))))
    else $error("DMA request does not follow its enable");

  no_restart_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == SAC_CONV) |=> (state_reg != SAC_SAMPLE && state_reg != SAC_IDLE))
    else $error("conversion restarted or aborted");

  chan_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg != SAC_IDLE && !$past(sar_preset)) |-> $stable(analog_o.chan))
    else $error("channel changed during a conversion");

  power_bits_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (analog_o.ref_en != ctrl_reg.bandgap_power_down) && (analog_o.standby == ctrl_reg.standby)
      && (analog_o.mux_en == ctrl_reg.mux_en))
    else $error("power controls disagree with register");

  result_read_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == `SAC_OFF_RESULT) |=>
      (reg_rdata_o == {22'h000000, $past(result_reg)}))
    else $error("result read data wrong");

endmodule

// ===== sac_analog_model.sv
// Purpose: Behavioural model of the analog core, input multiplexer and reference
// Assumes: Each input holds a fixed level, given as an ideal offset binary code
// Notes:   Comparator output is meaningless noise unless the core is fully powered
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_analog_model
  import sac_pkg::*;
#(
  parameter logic [79:0] LEVELS = 80'h0
)
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire sac_analog_type        analog_i,
  input  wire logic [`SAC_RES_W-1:0] dac_code_i,
  output logic                       comp_above_o
);
  logic [`SAC_RES_W-1:0] held_reg;
  logic                  noise_reg;
  logic                  powered;

  // Pins are taken as already switched to their analog function
  // Core only answers with mux on, reference on and standby released
  assign powered = analog_i.mux_en & analog_i.ref_en & ~analog_i.standby;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_reg  <= `SAC_RES_ZERO;
      noise_reg <= 1'b0;
    end else begin
      noise_reg <= ~noise_reg;
      // Sample-and-hold on the selected input, one input per sample
      if (analog_i.sample) begin
        held_reg <= LEVELS[analog_i.chan*10 +: 10];
      end
    end
  end

  // Ideal offset binary comparator: keep the trial bit while input is at or above it
  assign comp_above_o = powered ? (held_reg >= dac_code_i) : noise_reg;
endmodule

// ===== test_sac_top.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Divider of two or more so the comparator settles between steps
// Notes:   Rows cover every channel; hand tests cover reset, refusals and busy restarts
`timescale 1ns/1ps
`include "sac_cfg.svh"

module test_sac_top
  import sac_pkg::*;
;
  localparam logic [79:0] LEVELS = {10'h37c, 10'h001, 10'h2aa, 10'h155, 10'h1ff, 10'h200, 10'h000, 10'h3ff};

  typedef struct packed {
    logic [2:0] chan;
    logic [4:0] div;
    logic       int_en;
    logic       dma_en;
  } sac_row_type;

  logic                  core_clk_i;
  logic                  reset_n_i;
  logic [`SAC_ADDR_W-1:0] reg_addr_i;
  logic [31:0]           reg_wdata_i;
  logic                  reg_wr_i;
  logic                  reg_rd_i;
  logic [31:0]           reg_rdata_o;
  logic                  comp_above_i;
  sac_analog_type        analog_o;
  logic [`SAC_RES_W-1:0] dac_code_o;
  logic                  conv_clk_o;
  logic                  eoc_o;
  logic                  irq_o;
  logic                  dma_req_o;
  int                    n_errors;
  int                    check_count;
  sac_row_type           rows [8];
  logic [31:0]           rdata;
  logic [31:0]           ctrl;
  int                    n;
  int                    pulses;
  logic                  irq_seen;
  logic                  dma_seen;

  sac_top i_sac_top (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_wr_i     (reg_wr_i),
    .reg_rd_i     (reg_rd_i),
    .reg_rdata_o  (reg_rdata_o),
    .comp_above_i (comp_above_i),
    .analog_o     (analog_o),
    .dac_code_o   (dac_code_o),
    .conv_clk_o   (conv_clk_o),
    .eoc_o        (eoc_o),
    .irq_o        (irq_o),
    .dma_req_o    (dma_req_o)
  );

  sac_analog_model #(.LEVELS(LEVELS)) i_sac_analog_model (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .analog_i     (analog_o),
    .dac_code_i   (dac_code_o),
    .comp_above_o (comp_above_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= addr;
    reg_wdata_i <= data;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] addr, output logic [31:0] data);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= addr;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    data = reg_rdata_o;
  endtask

  // Counts edges from the start edge until the end-of-conversion pulse
  task automatic wait_eoc();
    n = 0;
    irq_seen = 1'b0;
    dma_seen = 1'b0;
    while (n < 1100) begin
      @(posedge core_clk_i);
      n++;
      #1;
      if (eoc_o === 1'b1) begin
        irq_seen = irq_o;
        dma_seen = dma_req_o;
        break;
      end
      chk("stray irq or dma", {irq_o, dma_req_o}, 2'b00);
    end
    if (eoc_o !== 1'b1) begin
      n_errors++;
      $display("ERROR end of conversion expected pulse seen none");
      wrap_up();
    end else begin
      @(posedge core_clk_i);
      #1;
      chk("eoc width", eoc_o, 1'b0);
    end
  endtask

  function automatic logic [31:0] ctrl_word(input sac_row_type r);
    return {17'h0, 1'b0, 1'b0, 1'b1, r.int_en, 1'b1, r.chan, 1'b0, r.div, 1'b1};
  endfunction

  initial begin
    n_errors    = 0;
    check_count = 0;
    reset_n_i   = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    // Run length does not depend on the divider; at this core clock no divider meets the rate limit
    rows = '{'{3'h0, 5'h02, 1'b1, 1'b0}, '{3'h1, 5'h03, 1'b0, 1'b1}, '{3'h2, 5'h1f, 1'b1, 1'b1},
             '{3'h3, 5'h02, 1'b0, 1'b0}, '{3'h4, 5'h04, 1'b1, 1'b0}, '{3'h5, 5'h02, 1'b0, 1'b1},
             '{3'h6, 5'h05, 1'b1, 1'b1}, '{3'h7, 5'h02, 1'b0, 1'b0}};
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;

    // Reset values
    #1;
    chk("analog after reset", {analog_o.mux_en, analog_o.ref_en, analog_o.standby}, 3'b001);
    rd(4'h0, rdata);
    chk("control reset", rdata, 32'h0000_6000);
    rd(4'h4, rdata);
    chk("result reset", rdata, 32'h0);
    rd(4'h8, rdata);
    chk("dma reset", rdata, 32'h0);
    repeat (50) begin
      @(posedge core_clk_i);
      #1;
      chk("gated clock", conv_clk_o, 1'b0);
    end
    $display("Reset test done");

    // Reference on and core released, then more than the wake-up time before any start
    wr(4'h0, 32'h0000_1400);
    #1;
    chk("power up", {analog_o.mux_en, analog_o.ref_en, analog_o.standby}, 3'b110);
    repeat (250) @(posedge core_clk_i);
    $display("Power up test done");

    // One conversion per row, every channel
    foreach (rows[i]) begin
      ctrl = ctrl_word(rows[i]);
      wr(4'h8, {31'h0, rows[i].dma_en});
      wr(4'h0, ctrl);
      #1;
      chk("preset", dac_code_o, `SAC_HALF_SCALE);
      chk("channel", analog_o.chan, rows[i].chan);
      chk("powered", {analog_o.mux_en, analog_o.ref_en, analog_o.standby}, 3'b110);
      wait_eoc();
      chk("conversion time", n >= 1000 && n <= 1010, 1'b1);
      chk("irq", irq_seen, rows[i].int_en);
      chk("dma request", dma_seen, rows[i].dma_en);
      rd(4'h4, rdata);
      chk("result", rdata, {22'h0, LEVELS[rows[i].chan*10 +: 10]});
      rd(4'h0, rdata);
      chk("start cleared", rdata, ctrl & ~32'h1);
      $display("Row %0d done", i);
    end

    // Divider: div 4 gives one pulse every five cycles
    wr(4'h0, 32'h0000_1408);
    pulses = 0;
    repeat (50) begin
      @(posedge core_clk_i);
      #1;
      pulses += conv_clk_o;
    end
    chk("clock pulses", pulses, 32'd10);
    $display("Divider test done");

    // Refused writes: read-only result, reserved bits; unmapped address reads zero
    wr(4'h4, 32'hffff_ffff);
    rd(4'h4, rdata);
    chk("result read only", rdata, {22'h0, LEVELS[70 +: 10]});
    wr(4'h8, 32'hffff_fffe);
    rd(4'h8, rdata);
    chk("dma reserved", rdata, 32'h0);
    wr(4'h0, 32'hffff_8040);
    rd(4'h0, rdata);
    chk("control reserved", rdata, 32'h0);
    rd(4'hc, rdata);
    chk("unmapped", rdata, 32'h0);
    $display("Refusal test done");

    // Start again mid-conversion on another channel: no restart, old channel kept
    ctrl = ctrl_word('{3'h5, 5'h02, 1'b1, 1'b0});
    wr(4'h0, ctrl);
    repeat (300) @(posedge core_clk_i);
    wr(4'h0, ctrl_word('{3'h2, 5'h02, 1'b1, 1'b0}));
    #1;
    chk("channel held", analog_o.chan, 3'h5);
    wait_eoc();
    chk("no restart", n >= 690 && n <= 710, 1'b1);
    rd(4'h4, rdata);
    chk("busy result", rdata, {22'h0, LEVELS[50 +: 10]});
    $display("Busy restart test done");

    // Start written in the finishing cycle: result lands and a new conversion begins at once
    wr(4'h0, ctrl_word('{3'h3, 5'h02, 1'b0, 1'b0}));
    repeat (998) @(posedge core_clk_i);
    wr(4'h0, ctrl_word('{3'h0, 5'h02, 1'b0, 1'b0}));
    #1;
    chk("finish eoc", eoc_o, 1'b1);
    chk("restart channel", analog_o.chan, 3'h0);
    rd(4'h4, rdata);
    chk("finish result", rdata, {22'h0, LEVELS[30 +: 10]});
    wait_eoc();
    chk("second time", n >= 990 && n <= 1005, 1'b1);
    rd(4'h4, rdata);
    chk("second result", rdata, {22'h0, LEVELS[9:0]});
    $display("Finish restart test done");
    wrap_up();
  end
endmodule
